//--- logic/phy_basic_control_regs.sv
// Management register space of the PHY, reached over the MDC/MDIO serial bus
//
// Operation
// R1: 32 registers addressable; 0h-Fh standard, 10h-1Fh vendor; unused ones read zero.
// R2: Writing one to bit 15 starts software reset; bit self-clears.
// R3: Bit 14 selects loopback; read-write, resets to zero.
// R4: Forced speed from bits 6 and 13: 10=1000, 01=100, 00=10, 11 reserved.
// R5: Speed select bits ignored while auto-negotiation enabled.
// R6: Bit 12 enables auto-negotiation, resets to one, result overrides forced bits.
// R7: Auto-negotiation off also disables auto crossover; register 1Ch selects crossover.
// R8: Manager treats link as down during power-down, ignoring link status.
// R9: Power-down bit going one to zero generates internal global reset; a write that also sets bit 15 runs only the software reset.
// R10: Manager waits 1 ms after leaving power-down before any access.
// R11: Bit 8 selects full duplex when one, only without auto-negotiation.
// R12: Software reset restores control defaults; reset bit reads zero when done.
`timescale 1ns/10ps
`default_nettype none

module phy_basic_control_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR        = 5'h01,
  parameter logic       SPEED_MSB_STRAP = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  input  wire logic [1:0]  an_speed_i,
  input  wire logic        an_duplex_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  output phy_ctl_type      ctl_o
);

  localparam logic [15:0] BC_DEFAULT = BC_RESET_BASE | {9'h000, SPEED_MSB_STRAP, 6'h00};

  logic [2:0]     mdc_s_r;
  logic [2:0]     mdio_s_r;
  logic           mdc_lvl_r;
  logic           mdio_lvl_r;
  logic           mdc_rise;
  logic           mdio_bit;
  mgmt_state_type state_r;
  logic [3:0]     cnt_r;
  logic [11:0]    hdr_r;
  logic [15:0]    sh_r;
  logic [15:0]    bc_r;
  logic [15:0]    mdix_r;
  logic [7:0]     sw_cnt_r;
  logic [7:0]     glb_cnt_r;
  logic           rst_busy;
  logic           hit;
  logic           rd_hit;
  logic           wr_commit;
  logic [15:0]    wdata;
  logic           wr_bc;
  logic           wr_mdix;
  logic           sw_start;
  logic           pd_exit;
  logic [15:0]    bc_view;

  // Readback view of a register; every address outside the two implemented ones is zero
  function automatic logic [15:0] reg_read(input logic [4:0] addr, input logic [15:0] bc,
                                           input logic [15:0] mdix, input logic busy);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == ADDR_BASIC_CTL) begin
      v = bc & BC_RW_MASK;
      v[BIT_SW_RESET] = busy;
    end else if (addr == ADDR_MDIX_CTL) begin
      v = mdix & MDIX_RW_MASK;
    end
    return v;
  endfunction

  // Pins cross in through three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mdc_s_r    <= 3'h0;
      mdio_s_r   <= 3'h7;
      mdc_lvl_r  <= 1'b0;
      mdio_lvl_r <= 1'b1;
    end else begin
      mdc_s_r  <= {mdc_s_r[1:0], mdc};
      mdio_s_r <= {mdio_s_r[1:0], mdio_i};
      if (mdc_s_r[1] == mdc_s_r[2]) begin
        mdc_lvl_r <= mdc_s_r[2];
      end
      if (mdio_s_r[1] == mdio_s_r[2]) begin
        mdio_lvl_r <= mdio_s_r[2];
      end
    end
  end

  assign mdc_rise  = mdc_s_r[1] & mdc_s_r[2] & ~mdc_lvl_r;
  assign mdio_bit  = (mdio_s_r[1] == mdio_s_r[2]) ? mdio_s_r[2] : mdio_lvl_r;
  assign hit       = (hdr_r[9:5] == PHY_ADDR);
  assign rd_hit    = hit && (hdr_r[11:10] == OP_READ);
  assign wdata     = {sh_r[14:0], mdio_bit};
  assign rst_busy  = (sw_cnt_r != 8'h00) || (glb_cnt_r != 8'h00);
  // R10: writes during the global reset window are dropped
  assign wr_commit = mdc_rise && (state_r == S_DATA) && (cnt_r == DATA_LAST) && hit &&
                     (hdr_r[11:10] == OP_WRITE) && !rst_busy;
  // R1: full 5-bit register address decoded
  assign wr_bc     = wr_commit && (hdr_r[4:0] == ADDR_BASIC_CTL);
  assign wr_mdix   = wr_commit && (hdr_r[4:0] == ADDR_MDIX_CTL);
  assign sw_start  = wr_bc && wdata[BIT_SW_RESET];
  assign pd_exit   = wr_bc && !wdata[BIT_SW_RESET] && bc_r[BIT_POWER_DOWN] &&
                     !wdata[BIT_POWER_DOWN];
  assign bc_view   = reg_read(ADDR_BASIC_CTL, bc_r, mdix_r, rst_busy);

  // Frame engine: preamble, start, 12 header bits, turnaround, 16 data bits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      cnt_r   <= 4'h0;
      hdr_r   <= 12'h000;
      sh_r    <= 16'h0000;
      mdio_o  <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        S_IDLE: begin
          if (!mdio_bit) begin
            state_r <= S_START;
          end
        end
        S_START: begin
          if (mdio_bit) begin
            state_r <= S_HDR;
            cnt_r   <= 4'h0;
          end
        end
        S_HDR: begin
          hdr_r <= {hdr_r[10:0], mdio_bit};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == HDR_LAST) begin
            state_r <= S_TA;
            cnt_r   <= 4'h0;
          end
        end
        S_TA: begin
          cnt_r <= cnt_r + 4'h1;
          // Second turnaround bit is driven low only by an addressed read
          if (rd_hit && (cnt_r == 4'h0)) begin
            mdio_oe <= 1'b1;
            mdio_o  <= 1'b0;
          end
          if (cnt_r == TA_LAST) begin
            state_r <= S_DATA;
            cnt_r   <= 4'h0;
            if (rd_hit) begin
              sh_r   <= reg_read(hdr_r[4:0], bc_r, mdix_r, rst_busy);
              mdio_o <= reg_read(hdr_r[4:0], bc_r, mdix_r, rst_busy) >> 15 != 16'h0000;
            end
          end
        end
        S_DATA: begin
          cnt_r  <= cnt_r + 4'h1;
          sh_r   <= wdata;
          mdio_o <= sh_r[14];
          if (cnt_r == DATA_LAST) begin
            state_r <= S_IDLE;
            mdio_oe <= 1'b0;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // R2: reset pulse length counted down after a write of one to bit 15
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_cnt_r  <= 8'h00;
      glb_cnt_r <= 8'h00;
    end else begin
      if (sw_start) begin
        sw_cnt_r <= SW_RST_CYC;
      end else if (sw_cnt_r != 8'h00) begin
        sw_cnt_r <= sw_cnt_r - 8'h01;
      end
      // R9: leaving power-down by a write with bit 15 clear fires the global reset
      if (pd_exit) begin
        glb_cnt_r <= GLB_RST_CYC;
      end else if (glb_cnt_r != 8'h00) begin
        glb_cnt_r <= glb_cnt_r - 8'h01;
      end
    end
  end

  // Control fields; bit 15 and bit 9 are never stored; bit 9 reads back cleared, bit 15 reads one only while a reset runs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bc_r   <= BC_DEFAULT;
      mdix_r <= 16'h0000;
    end else if (sw_start || pd_exit) begin
      // R12: software reset returns basic control fields to defaults; 1Ch keeps its value and clears only on power-down exit
      bc_r   <= BC_DEFAULT;
      mdix_r <= pd_exit ? 16'h0000 : mdix_r;
    end else begin
      // R3: loopback and the other read-write fields
      if (wr_bc) begin
        bc_r <= wdata & BC_RW_MASK;
      end
      if (wr_mdix) begin
        mdix_r <= wdata & MDIX_RW_MASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_o <= '0;
    end else begin
      ctl_o.loopback   <= bc_r[BIT_LOOPBACK];
      ctl_o.power_down <= bc_r[BIT_POWER_DOWN];
      ctl_o.isolate    <= bc_r[BIT_ISOLATE];
      ctl_o.an_enable  <= bc_r[BIT_AN_ENABLE];
      ctl_o.an_restart <= wr_bc && !wdata[BIT_SW_RESET] && wdata[BIT_AN_RESTART];
      ctl_o.phy_reset  <= rst_busy || sw_start || pd_exit;
      // R4: forced speed pair
      // R5: speed bits ignored
      // R6: negotiated result wins
      ctl_o.speed      <= bc_r[BIT_AN_ENABLE] ? an_speed_i
                                             : {bc_r[BIT_SPEED_MSB], bc_r[BIT_SPEED_LSB]};
      // R11: forced duplex only without auto-negotiation
      ctl_o.duplex_full <= bc_r[BIT_AN_ENABLE] ? an_duplex_i : bc_r[BIT_DUPLEX];
      // R7: auto crossover needs auto-negotiation; otherwise 1Ch picks the pair use
      ctl_o.mdix_auto  <= bc_r[BIT_AN_ENABLE] && !mdix_r[BIT_MDIX_OFF];
      ctl_o.mdi_select <= mdix_r[BIT_MDIX_MDI];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_sw_reset_load: assert property (sw_start |=> sw_cnt_r == SW_RST_CYC) // R2
    else $error("software reset count not loaded");
  a_sw_reset_done: assert property ((sw_cnt_r == 8'h01) && (glb_cnt_r <= 8'h01) && // R12
    !sw_start |=> bc_view[BIT_SW_RESET] == 1'b0)
    else $error("reset bit still set after reset");
  a_sw_defaults: assert property (sw_start |=> bc_r == BC_DEFAULT) // R12
    else $error("software reset did not restore defaults");
  a_loop_write: assert property (wr_bc && !sw_start && !pd_exit |=> ##1 // R3
    ctl_o.loopback == $past(wdata[BIT_LOOPBACK], 2))
    else $error("loopback output does not follow write");
  a_speed_forced: assert property (!bc_r[BIT_AN_ENABLE] && bc_r[BIT_SPEED_MSB] && // R4
    !bc_r[BIT_SPEED_LSB] |=> ctl_o.speed == SPD_1000)
    else $error("forced 1000 not decoded");
  a_speed_an: assert property (bc_r[BIT_AN_ENABLE] |=> // R5
    ctl_o.speed == $past(an_speed_i) && ctl_o.duplex_full == $past(an_duplex_i))
    else $error("negotiated result not applied");
  a_duplex_forced: assert property (!bc_r[BIT_AN_ENABLE] |=> // R11
    ctl_o.duplex_full == $past(bc_r[BIT_DUPLEX]))
    else $error("forced duplex not applied");
  a_mdix_off: assert property (!bc_r[BIT_AN_ENABLE] |=> !ctl_o.mdix_auto) // R7
    else $error("auto crossover left on");
  a_pd_global: assert property (pd_exit |=> ctl_o.phy_reset [*8]) // R9
    else $error("no global reset after power-down exit");
  a_unmapped_zero: assert property (mdc_rise && state_r == S_TA && cnt_r == TA_LAST && // R1
    rd_hit && hdr_r[4:0] != ADDR_BASIC_CTL && hdr_r[4:0] != ADDR_MDIX_CTL
    |=> sh_r == 16'h0000)
    else $error("unimplemented register not read as zero");
  a_an_default: assert property ($rose(rst_b) |-> bc_r[BIT_AN_ENABLE]) // R6
    else $error("auto-negotiation not enabled at reset");

  c_sw_reset: cover property (sw_start ##1 sw_cnt_r == 8'h01);
  c_pd_exit: cover property (pd_exit);
  c_read: cover property (mdio_oe ##1 !mdio_oe);
  c_write_mdix: cover property (wr_mdix);

endmodule

`default_nettype wire

//--- logic/phy_mgmt_pkg.sv
// Constants, field positions and carrier types for the PHY management registers
package phy_mgmt_pkg;

  localparam int          REG_COUNT      = 32;
  localparam logic [4:0]  ADDR_BASIC_CTL = 5'h00;
  localparam logic [4:0]  ADDR_VENDOR    = 5'h10;
  localparam logic [4:0]  ADDR_MDIX_CTL  = 5'h1C;

  // Basic control field positions
  localparam int          BIT_SW_RESET   = 15;
  localparam int          BIT_LOOPBACK   = 14;
  localparam int          BIT_SPEED_LSB  = 13;
  localparam int          BIT_AN_ENABLE  = 12;
  localparam int          BIT_POWER_DOWN = 11;
  localparam int          BIT_ISOLATE    = 10;
  localparam int          BIT_AN_RESTART = 9;
  localparam int          BIT_DUPLEX     = 8;
  localparam int          BIT_SPEED_MSB  = 6;
  localparam logic [15:0] BC_RESET_BASE  = 16'h1100;
  localparam logic [15:0] BC_RW_MASK     = 16'h7DC0;

  // Crossover control field positions
  localparam int          BIT_MDIX_MDI   = 7;
  localparam int          BIT_MDIX_OFF   = 6;
  localparam logic [15:0] MDIX_RW_MASK   = 16'h00C0;

  // Management frame
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [3:0]  HDR_LAST       = 4'hB;
  localparam logic [3:0]  TA_LAST        = 4'h1;
  localparam logic [3:0]  DATA_LAST      = 4'hF;

  localparam logic [1:0]  SPD_10         = 2'h0;
  localparam logic [1:0]  SPD_100        = 2'h1;
  localparam logic [1:0]  SPD_1000       = 2'h2;

  // Reset pulse lengths
  localparam int          CLK_MHZ        = 40;
  localparam int          SW_RST_NS      = 1000;
  localparam int          GLB_RST_NS     = 2000;
  localparam logic [7:0]  SW_RST_CYC     = 8'((SW_RST_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  GLB_RST_CYC    = 8'((GLB_RST_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [2:0] {S_IDLE, S_START, S_HDR, S_TA, S_DATA} mgmt_state_type;

  typedef struct packed {
    logic       loopback;
    logic       power_down;
    logic       isolate;
    logic       an_enable;
    logic       an_restart;
    logic       duplex_full;
    logic       mdix_auto;
    logic       mdi_select;
    logic       phy_reset;
    logic [1:0] speed;
  } phy_ctl_type;

endpackage

//--- test/mdio_station.sv
// Station management master model on the MDC/MDIO pins
`timescale 1ns/10ps
`default_nettype none

module mdio_station
  import phy_mgmt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_wire
);
  logic drv;
  logic drv_bit;

  // Pull-up wins whenever nobody drives the line
  assign mdio_wire = mdio_oe ? mdio_o : (drv ? drv_bit : 1'b1);

  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    drv_bit = 1'b1;
  end

  // Six-cycle half period leaves room for the three-flop pin sync
  task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [15:0] rdat);
    logic [63:0] fr;
    fr = {32'hFFFFFFFF, 2'b01, (rd ? OP_READ : OP_WRITE), phy, rg, 2'b10, wd};
    rdat = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge core_clk);
      #1;
      mdc = 1'b0;
      drv = !(rd && i >= 46);
      drv_bit = fr[63-i];
      repeat (6) @(posedge core_clk);
      #1;
      if (i >= 48) begin
        rdat = {rdat[14:0], mdio_wire};
      end
      mdc = 1'b1;
      repeat (5) @(posedge core_clk);
    end
    @(posedge core_clk);
    #1;
    mdc = 1'b0;
    drv = 1'b0;
    repeat (6) @(posedge core_clk);
    // Callers then drive inputs off the edge, not in its time step
    #1;
  endtask
endmodule

`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the PHY management registers
`timescale 1ns/10ps
`default_nettype none

module testbench
  import phy_mgmt_pkg::*;
;
  localparam logic [4:0] PHY = 5'h01;
  logic        core_clk;
  logic        rst_b;
  logic        mdc;
  logic        mdio_wire;
  logic [1:0]  an_speed_i;
  logic        an_duplex_i;
  logic        mdio_o;
  logic        mdio_oe;
  phy_ctl_type ctl;
  logic [15:0] v;
  int          num_errors;
  int          check_count;
  int          restart_seen;

  phy_basic_control_regs #(.PHY_ADDR(PHY)) u_phy_basic_control_regs (
    .core_clk(core_clk), .rst_b(rst_b), .mdc(mdc), .mdio_i(mdio_wire),
    .an_speed_i(an_speed_i), .an_duplex_i(an_duplex_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .ctl_o(ctl));

  mdio_station u_mdio_station (
    .core_clk(core_clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_wire(mdio_wire));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Counts restart pulses; a stuck pulse shows up as a count above one
  always @(posedge core_clk) begin
    if (ctl.an_restart === 1'b1) begin
      restart_seen++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    logic [15:0] unused;
    u_mdio_station.xfer(1'b0, PHY, rg, d, unused);
  endtask

  task automatic rd(input logic [4:0] rg, output logic [15:0] d);
    u_mdio_station.xfer(1'b1, PHY, rg, 16'h0000, d);
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    an_speed_i = SPD_1000;
    an_duplex_i = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ADDR_BASIC_CTL, v);
    check(v, 16'h1140);
    check(16'(ctl.an_enable), 16'h0001);
    check(16'(ctl.speed), 16'(SPD_1000));
    for (int k = 0; k < 4; k++) begin
      v = 16'h4000 | (k[0] ? 16'h2000 : 16'h0100) | (k[1] ? 16'h0040 : 16'h0000);
      wr(ADDR_BASIC_CTL, v);
      check(16'(ctl.speed), 16'(k));
      check(16'(ctl.loopback), 16'h0001);
      check(16'(ctl.duplex_full), 16'(!k[0]));
      check(16'(ctl.mdix_auto), 16'h0000);
      rd(ADDR_BASIC_CTL, v);
      check(16'(v[15:8]), 16'h40 | (k[0] ? 16'h20 : 16'h01));
    end
    wr(ADDR_MDIX_CTL, 16'h0080);
    check(16'(ctl.mdi_select), 16'h0001);
    an_speed_i = SPD_100;
    an_duplex_i = 1'b0;
    wr(ADDR_BASIC_CTL, 16'h3740);
    check(16'(ctl.speed), 16'(SPD_100));
    check(16'(ctl.duplex_full), 16'h0000);
    check(16'(ctl.mdix_auto), 16'h0001);
    check(16'(ctl.isolate), 16'h0001);
    check(16'(restart_seen), 16'h0001);
    wr(ADDR_BASIC_CTL, 16'hC000);
    check(16'(ctl.phy_reset), 16'h0001);
    repeat (50) @(posedge core_clk);
    rd(ADDR_BASIC_CTL, v);
    check(v, 16'h1140);
    check(16'(ctl.loopback), 16'h0000);
    check(16'(ctl.isolate), 16'h0000);
    wr(ADDR_MDIX_CTL, 16'h00C0);
    wr(ADDR_BASIC_CTL, 16'h1940);
    check(16'(ctl.power_down), 16'h0001);
    wr(ADDR_BASIC_CTL, 16'h1140);
    // one millisecond of silence after leaving power-down
    repeat (40000) @(posedge core_clk);
    rd(ADDR_MDIX_CTL, v);
    check(v, 16'h0000);
    check(16'(ctl.power_down), 16'h0000);
    u_mdio_station.xfer(1'b0, 5'h02, ADDR_BASIC_CTL, 16'h4000, v);
    check(16'(ctl.loopback), 16'h0000);
    u_mdio_station.xfer(1'b1, 5'h02, ADDR_BASIC_CTL, 16'h0000, v);
    check(v, 16'hFFFF);
    wr(ADDR_VENDOR, 16'hA5A5);
    rd(ADDR_VENDOR, v);
    check(v, 16'h0000);
    end_of_test();
  end
endmodule

`default_nettype wire
